/* File: acc_pkg.sv */
// Purpose: shared constants for the analog comparator control block
// Assumes: one clock, synchronous active-low reset
// Notes: register offsets are byte addresses of aligned 32-bit words
package acc_pkg;
	localparam int ACC_AW = 4;
	localparam logic [3:0] ACC_OFS_CMP = 4'h0;
	localparam logic [3:0] ACC_OFS_REF = 4'h4;
	localparam logic [3:0] ACC_OFS_IRQ = 4'h8;
	localparam logic [3:0] ACC_OFS_PORT = 4'hC;
	// comparator control fields
	localparam int ACC_SECOND_RESULT_BIT_B = 7;
	localparam int ACC_FIRST_RESULT_BIT_B = 6;
	localparam int ACC_SECOND_RESULT_INVERT_B = 5;
	localparam int ACC_FIRST_RESULT_INVERT_B = 4;
	localparam int ACC_SW_B = 3;
	localparam int ACC_MODE_HI = 2;
	localparam logic [7:0] ACC_CMP_RST = 8'h07;
	localparam logic [7:0] ACC_CMP_WMASK = 8'h3F;
	// reference control fields
	localparam int ACC_REN_B = 7;
	localparam int ACC_ROE_B = 6;
	localparam int ACC_RNG_B = 5;
	localparam int ACC_RSS_B = 4;
	localparam int ACC_LVL_HI = 3;
	localparam logic [7:0] ACC_REF_RST = 8'h00;
	// irq register: flag, enable, peripheral enable, global enable
	localparam int ACC_IF_B = 0;
	localparam int ACC_IE_B = 1;
	localparam int ACC_PE_B = 2;
	localparam int ACC_GE_B = 3;
	localparam logic [3:0] ACC_IRQ_RST = 4'h0;
	// port register: direction bits of the two output pins, converter cfg
	localparam int ACC_DIR1_B = 0;
	localparam int ACC_DIR2_B = 1;
	localparam int ACC_PCFG_LO = 4;
	localparam logic [7:0] ACC_PORT_RST = 8'h03;
	localparam logic [3:0] ACC_PCFG_ALLAN = 4'h0;
	// modes
	localparam logic [2:0] ACC_M_RST_IN = 3'b000;
	localparam logic [2:0] ACC_M_1IND = 3'b001;
	localparam logic [2:0] ACC_M_2IND = 3'b010;
	localparam logic [2:0] ACC_M_2OUT = 3'b011;
	localparam logic [2:0] ACC_M_2COM = 3'b100;
	localparam logic [2:0] ACC_M_COMOUT = 3'b101;
	localparam logic [2:0] ACC_M_4MUX = 3'b110;
	localparam logic [2:0] ACC_M_OFF = 3'b111;
	// ladder arithmetic in 1/96 of the source span
	localparam int ACC_LW = 8;
	localparam logic [7:0] ACC_HI_STEP = 8'h04;
	localparam logic [7:0] ACC_LO_STEP = 8'h03;
	localparam logic [7:0] ACC_LO_BASE = 8'h18;
endpackage

/* File: acc_sync.sv */
// Purpose: two-flop synchroniser for the comparator results
// Assumes: din is asynchronous to clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module acc_sync #(
	parameter int W = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_q;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s1_q <= '0;
			dout <= '0;
		end
		else
		begin
			s1_q <= din;
			dout <= s1_q;
		end
	end
endmodule

/* File: acc_top.sv */
// Purpose: analog comparator pair control, ladder reference, change flag
// Assumes: Avalon-MM slave, 32-bit words, one clock, sync reset
// Notes: analog front end lives outside; only selects and levels here
`timescale 1ns/1ps
module acc_top
	import acc_pkg::*;
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [acc_pkg::ACC_AW-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic [1:0] CMP_RAW,
	input wire logic SLEEP,
	output logic [1:0] CMP_EN,
	output logic [1:0] POS_SEL_REF,
	output logic [1:0] NEG_SEL,
	output logic [1:0] POS_SEL,
	output logic [1:0] ROUTE_OUT,
	output logic [1:0] PIN_OUT,
	output logic [1:0] PIN_OE,
	output logic [3:0] ANALOG_IN_CFG,
	output logic LADDER_ON,
	output logic LADDER_EXT_SUPPLY,
	output logic [acc_pkg::ACC_LW-1:0] LADDER_LEVEL,
	output logic LADDER_PIN_OE,
	output logic IRQ,
	output logic WAKE
);
	import acc_pkg::*;
	////////////////////////////////////////////////////////////////////
	logic [7:0] cmp_q;
	logic [7:0] ref_q;
	logic [3:0] irq_q;
	logic [7:0] port_q;
	logic [1:0] latch_q;
	logic rst_seen_q;
	logic ack_q;
	logic [1:0] res_sync;
	logic [1:0] res_raw;
	logic [2:0] mode;
	logic inv1;
	logic inv2;
	logic req;
	logic wr;
	logic rd;
	logic sel_cmp;
	logic mismatch;
	logic [7:0] wbyte;

	function automatic logic [7:0] level_of(input logic rng,
		input logic [3:0] code);
		logic [7:0] c;
		c = {4'h0, code};
		if (rng)
			level_of = 8'(c * ACC_HI_STEP);
		else
			level_of = 8'(ACC_LO_BASE + c * ACC_LO_STEP);
	endfunction

	assign mode = cmp_q[ACC_MODE_HI:0];
	assign inv1 = cmp_q[ACC_FIRST_RESULT_INVERT_B];
	assign inv2 = cmp_q[ACC_SECOND_RESULT_INVERT_B];
	assign wbyte = AVS_WRITEDATA[7:0];
	////////////////////////////////////////////////////////////////////
	// bus: one wait cycle, answer on the second edge of the request
	assign req = (AVS_READ || AVS_WRITE) && !ack_q;
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_q;
	assign wr = AVS_WRITE && ack_q && AVS_BYTEENABLE[0];
	assign rd = AVS_READ && ack_q;
	assign sel_cmp = (AVS_ADDRESS == ACC_OFS_CMP);

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
			ack_q <= 1'b0;
		else
			ack_q <= req;
	end

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
			AVS_READDATA <= '0;
		else if (req && AVS_READ)
		begin
			unique case (AVS_ADDRESS)
				ACC_OFS_CMP: AVS_READDATA <= {24'h0, ROUTE_OUT[1],
					ROUTE_OUT[0], cmp_q[5:0]};
				ACC_OFS_REF: AVS_READDATA <= {24'h0, ref_q};
				ACC_OFS_IRQ: AVS_READDATA <= {28'h0, irq_q};
				ACC_OFS_PORT: AVS_READDATA <= {24'h0, port_q};
				default: AVS_READDATA <= '0;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////
	// control register; sleep has no path in, so it is kept
	always_ff @(posedge CLK)
	begin
		if (!RESETN)
			cmp_q <= ACC_CMP_RST;
		else if (wr && sel_cmp)
			cmp_q <= wbyte & ACC_CMP_WMASK;
	end

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
			ref_q <= ACC_REF_RST;
		else if (wr && AVS_ADDRESS == ACC_OFS_REF)
			ref_q <= wbyte;
	end

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
			port_q <= ACC_PORT_RST;
		else if (wr && AVS_ADDRESS == ACC_OFS_PORT)
			port_q <= wbyte;
	end
	////////////////////////////////////////////////////////////////////
	// mode decode: enables and input routing
	always_comb
	begin
		CMP_EN = 2'b11;
		POS_SEL_REF = 2'b00;
		POS_SEL = 2'b00;
		NEG_SEL = 2'b00;
		unique case (mode)
			ACC_M_RST_IN: CMP_EN = 2'b00;
			ACC_M_1IND: CMP_EN = 2'b01;
			ACC_M_2IND: NEG_SEL = 2'b00;
			ACC_M_2OUT: NEG_SEL = 2'b00;
			ACC_M_2COM: POS_SEL = 2'b11;
			ACC_M_COMOUT: CMP_EN = 2'b10;
			ACC_M_4MUX:
			begin
				POS_SEL_REF = 2'b11;
				NEG_SEL = cmp_q[ACC_SW_B] ? 2'b11 : 2'b00;
			end
			ACC_M_OFF: CMP_EN = 2'b00;
		endcase
	end

	// raw result, 1 when positive above negative, then polarity
	assign res_raw = CMP_RAW & CMP_EN;
	assign ROUTE_OUT = {res_raw[1] ^ inv2, res_raw[0] ^ inv1};
	// unsynchronised path to the pins; glitches are the user's lookout
	assign PIN_OUT = ROUTE_OUT;
	always_comb
	begin
		PIN_OE = 2'b00;
		if (mode == ACC_M_2OUT || mode == ACC_M_COMOUT)
		begin
			PIN_OE[0] = !port_q[ACC_DIR1_B];
			PIN_OE[1] = !port_q[ACC_DIR2_B];
		end
	end
	assign ANALOG_IN_CFG = port_q[ACC_PCFG_LO +: 4];
	////////////////////////////////////////////////////////////////////
	// ladder reference
	assign LADDER_ON = ref_q[ACC_REN_B];
	assign LADDER_EXT_SUPPLY = ref_q[ACC_RSS_B];
	assign LADDER_PIN_OE = ref_q[ACC_ROE_B];
	always_ff @(posedge CLK)
	begin
		if (!RESETN)
			LADDER_LEVEL <= '0;
		else
			LADDER_LEVEL <= level_of(ref_q[ACC_RNG_B],
				ref_q[ACC_LVL_HI:0]);
	end
	////////////////////////////////////////////////////////////////////
	// change detect on synchronised results
	acc_sync #(.W(2)) u_sync (
		.clk(CLK),
		.rst_n(RESETN),
		.din(ROUTE_OUT),
		.dout(res_sync)
	);

	assign mismatch = rst_seen_q && (res_sync != latch_q);

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
			rst_seen_q <= 1'b0;
		else
			rst_seen_q <= 1'b1;
	end

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
			latch_q <= '0;
		else if (!rst_seen_q || ((rd || wr) && sel_cmp))
			latch_q <= res_sync;
	end

	// flag: hardware set wins over a software clear
	always_ff @(posedge CLK)
	begin
		if (!RESETN)
			irq_q <= ACC_IRQ_RST;
		else
		begin
			if (wr && AVS_ADDRESS == ACC_OFS_IRQ)
				irq_q <= wbyte[3:0];
			if (mismatch)
				irq_q[ACC_IF_B] <= 1'b1;
		end
	end

	assign IRQ = irq_q[ACC_IF_B] && irq_q[ACC_IE_B] && irq_q[ACC_PE_B]
		&& irq_q[ACC_GE_B];
	// wake needs only the comparator enable; logic runs in sleep
	assign WAKE = SLEEP && irq_q[ACC_IF_B] && irq_q[ACC_IE_B];
	////////////////////////////////////////////////////////////////////
	property p_ro_bits;
		@(posedge CLK) disable iff (!RESETN)
		(wr && sel_cmp) |=> (cmp_q[7:6] == 2'b00);
	endproperty
	a_ro_bits: assert property (p_ro_bits)
		else $error("result bits stored in control register");

	property p_flag_set;
		@(posedge CLK) disable iff (!RESETN)
		mismatch |=> irq_q[ACC_IF_B];
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("change not flagged");

	sequence s_access;
		(rd || wr) && sel_cmp;
	endsequence
	property p_latch;
		@(posedge CLK) disable iff (!RESETN)
		s_access ##1 $stable(res_sync) |-> !mismatch;
	endproperty
	a_latch: assert property (p_latch)
		else $error("access did not end mismatch");

	property p_irq_gate;
		@(posedge CLK) disable iff (!RESETN)
		IRQ |-> irq_q == 4'hF;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt without all enables");

	property p_ref_mode;
		@(posedge CLK) disable iff (!RESETN)
		(POS_SEL_REF != 2'b00) |-> mode == ACC_M_4MUX;
	endproperty
	a_ref_mode: assert property (p_ref_mode)
		else $error("reference outside mux mode");

	property p_off;
		@(posedge CLK) disable iff (!RESETN)
		(mode == ACC_M_OFF) |-> CMP_EN == 2'b00;
	endproperty
	a_off: assert property (p_off)
		else $error("comparators on in off mode");

	property p_clear;
		@(posedge CLK) disable iff (!RESETN)
		(wr && AVS_ADDRESS == ACC_OFS_IRQ && !wbyte[ACC_IF_B]
			&& !mismatch) |=> !irq_q[ACC_IF_B];
	endproperty
	a_clear: assert property (p_clear)
		else $error("flag not cleared by zero write");

	property p_no_spur;
		@(posedge CLK)
		$rose(RESETN) |-> !irq_q[ACC_IF_B] [*2];
	endproperty
	a_no_spur: assert property (p_no_spur)
		else $error("flag raised on reset release");

	property p_level;
		@(posedge CLK) disable iff (!RESETN)
		ref_q[ACC_RNG_B] && $stable(ref_q) |->
			LADDER_LEVEL == 8'(ref_q[ACC_LVL_HI:0] * ACC_HI_STEP);
	endproperty
	a_level: assert property (p_level)
		else $error("ladder level wrong");

	// level register lags reset by one edge, so skip that edge
	property p_level_lo;
		@(posedge CLK) disable iff (!RESETN)
		!ref_q[ACC_RNG_B] && $stable(ref_q) && rst_seen_q |->
			LADDER_LEVEL == 8'(ACC_LO_BASE
				+ ref_q[ACC_LVL_HI:0] * ACC_LO_STEP);
	endproperty
	a_level_lo: assert property (p_level_lo)
		else $error("low range ladder level wrong");

	property p_wake;
		@(posedge CLK) disable iff (!RESETN)
		SLEEP && irq_q[ACC_IE_B] && mismatch
			&& !(wr && AVS_ADDRESS == ACC_OFS_IRQ) |=> WAKE || !SLEEP;
	endproperty
	a_wake: assert property (p_wake)
		else $error("change in sleep did not wake");

	property p_no_cause;
		@(posedge CLK) disable iff (!RESETN)
		!irq_q[ACC_IF_B] && !mismatch
			&& !(wr && AVS_ADDRESS == ACC_OFS_IRQ) |=> !irq_q[ACC_IF_B];
	endproperty
	a_no_cause: assert property (p_no_cause)
		else $error("flag set without a change");

	property p_pin_dir;
		@(posedge CLK) disable iff (!RESETN)
		port_q[ACC_DIR2_B] |-> !PIN_OE[1];
	endproperty
	a_pin_dir: assert property (p_pin_dir)
		else $error("routed pin driven while set as input");
endmodule

/* File: acc_analog_model.sv */
// Purpose: far side model: pin levels against ladder or pin levels
// Assumes: levels in 1/96 of the span, same scale as the ladder code
// Notes: an idle comparator reads low, never the last result
`timescale 1ns/1ps
module acc_analog_model
	import acc_pkg::*;
(
	input wire logic [1:0] cmp_en,
	input wire logic [1:0] pos_sel_ref,
	input wire logic [acc_pkg::ACC_LW-1:0] ladder_level,
	input wire logic [1:0][7:0] vin_pos,
	input wire logic [1:0][7:0] vin_neg,
	output logic [1:0] raw
);
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			// ladder replaces the positive pin where selected
			raw[i] = cmp_en[i] &&
				((pos_sel_ref[i] ? ladder_level : vin_pos[i]) > vin_neg[i]);
		end
	end
endmodule

/* File: acc_top_test.sv */
// Purpose: self-checking bench for the comparator control block
// Assumes: bus master waits on waitrequest, no fixed latency
// Notes: rows cover modes and ladder; hand tests cover flag and pins
`timescale 1ns/1ps
module acc_top_test;
	import acc_pkg::*;
	logic clk, rst_n, rd, wr, slp, irq, wake, wreq, lon, lext, loe;
	logic [3:0] adr, acfg;
	logic [31:0] wd, rdat, q;
	logic [1:0] raw, en, psr, nsel, psel, rout, pout, poe;
	logic [7:0] llev;
	logic [1:0][7:0] vp, vn;
	logic [34:0] rows [12];
	int miscompares, comparisons;
	////////////////////////////////////////////////////////////////////
	acc_top u_acc_top (.CLK(clk), .RESETN(rst_n), .AVS_ADDRESS(adr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
		.AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
		.AVS_WAITREQUEST(wreq), .CMP_RAW(raw), .SLEEP(slp),
		.CMP_EN(en), .POS_SEL_REF(psr), .NEG_SEL(nsel), .POS_SEL(psel),
		.ROUTE_OUT(rout), .PIN_OUT(pout), .PIN_OE(poe),
		.ANALOG_IN_CFG(acfg), .LADDER_ON(lon), .LADDER_EXT_SUPPLY(lext),
		.LADDER_LEVEL(llev), .LADDER_PIN_OE(loe), .IRQ(irq), .WAKE(wake));
	acc_analog_model u_acc_analog_model (.cmp_en(en), .pos_sel_ref(psr),
		.ladder_level(llev), .vin_pos(vp), .vin_neg(vn), .raw(raw));
	always #25 clk = ~clk;
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH at %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one gap cycle before each request keeps drives one per step
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= 32'(d);
		// waitrequest and read data are both taken at the rising edge
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wreq !== 1'b0 && n < 20);
		q = rdat;
		if (n >= 20)
			miscompares++;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(q, 32'(e));
	endtask
	task automatic end_of_test();
		$display("comparisons %0d miscompares %0d", comparisons,
			miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge clk);
		miscompares++;
		end_of_test();
	end
	////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		adr = 4'h0;
		wd = 32'h0000_0000;
		slp = 1'b0;
		vp = 16'h0000;
		vn = 16'h8080;
		// addr, write, readback, {en, pos ref, on, ext, pin oe, level}
		rows = '{{4'h0, 8'h00, 8'h00, 15'h0018},
			{4'h0, 8'h01, 8'h01, 15'h2018}, {4'h0, 8'h02, 8'h02, 15'h6018},
			{4'h0, 8'h03, 8'h03, 15'h6018}, {4'h0, 8'h04, 8'h04, 15'h6018},
			{4'h0, 8'hC5, 8'h05, 15'h4018}, {4'h0, 8'h0E, 8'h0E, 15'h7818},
			{4'h0, 8'h07, 8'h07, 15'h0018}, {4'h4, 8'hAF, 8'hAF, 15'h043C},
			{4'h4, 8'h50, 8'h50, 15'h0318}, {4'h4, 8'h8F, 8'h8F, 15'h0445},
			{4'h4, 8'h20, 8'h20, 15'h0000}};
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rdc(ACC_OFS_CMP, 8'h07);
		rdc(ACC_OFS_REF, 8'h00);
		rdc(ACC_OFS_IRQ, 8'h00);
		rdc(ACC_OFS_PORT, 8'h03);
		rdc(4'h2, 8'h00);
		chk(32'(en), 32'h0000_0000);
		chk(32'(acfg), 32'h0000_0000);
		$display("reset test done");
		foreach (rows[i])
		begin
			bus(1'b1, rows[i][34:31], rows[i][30:23]);
			rdc(rows[i][34:31], rows[i][22:15]);
			@(negedge clk);
			chk(32'({en, psr, lon, lext, loe, llev}), 32'(rows[i][14:0]));
		end
		$display("table test done");
		bus(1'b1, ACC_OFS_CMP, 8'h02);
		bus(1'b1, ACC_OFS_IRQ, 8'h0E);
		rdc(ACC_OFS_CMP, 8'h02);
		@(posedge clk);
		vp[0] <= 8'hFF;
		slp <= 1'b1;
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk(32'(irq), 32'h0000_0001);
		chk(32'(wake), 32'h0000_0001);
		bus(1'b1, ACC_OFS_IRQ, 8'h0E);
		rdc(ACC_OFS_IRQ, 8'h0F);
		rdc(ACC_OFS_CMP, 8'h42);
		bus(1'b1, ACC_OFS_IRQ, 8'h0E);
		rdc(ACC_OFS_IRQ, 8'h0E);
		bus(1'b1, ACC_OFS_IRQ, 8'h0F);
		rdc(ACC_OFS_IRQ, 8'h0F);
		bus(1'b1, ACC_OFS_IRQ, 8'h06);
		@(posedge clk);
		vp[0] <= 8'h00;
		slp <= 1'b0;
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk(32'(irq), 32'h0000_0000);
		rdc(ACC_OFS_IRQ, 8'h07);
		rdc(ACC_OFS_CMP, 8'h02);
		$display("flag test done");
		// pin1 driven, pin2 left as input; converter config all ones
		bus(1'b1, ACC_OFS_PORT, 8'hF2);
		@(negedge clk);
		chk(32'(acfg), 32'h0000_000F);
		bus(1'b1, ACC_OFS_CMP, 8'h13);
		rdc(ACC_OFS_CMP, 8'h53);
		@(posedge clk);
		vp[1] <= 8'hFF;
		@(negedge clk);
		chk(32'(rout), 32'h0000_0003);
		chk(32'(pout), 32'h0000_0003);
		chk(32'(poe), 32'h0000_0001);
		bus(1'b1, ACC_OFS_CMP, 8'h0E);
		@(negedge clk);
		chk(32'({nsel, psr}), 32'h0000_000F);
		bus(1'b1, ACC_OFS_CMP, 8'h06);
		@(negedge clk);
		chk(32'(nsel), 32'h0000_0000);
		bus(1'b1, ACC_OFS_CMP, 8'h04);
		@(negedge clk);
		chk(32'({psel, psr}), 32'h0000_000C);
		$display("pin test done");
		end_of_test();
	end
endmodule
